//--- inc/rtcc_pkg.sv
/*
  Shared constants and types for the clock control/status block.
  Assumes a 25 MHz system clock.
*/
package rtcc_pkg;
  localparam logic [7:0] CTL_ADDR = 8'h0e;
  localparam logic [7:0] STS_ADDR = 8'h0f;
  localparam logic [7:0] CTL_RST = 8'h1c;
  localparam logic [7:0] STS_RST = 8'h88;
  localparam int CONVERT_TEMPERATURE_BIT = 5;
  localparam int OSF_BIT = 7;
  localparam int EN32_BIT = 3;
  localparam int A2F_BIT = 1;
  localparam int A1F_BIT = 0;
  localparam int CLK_HZ = 25000000;
  localparam int BUSY_DELAY_MS = 2;
  localparam int BUSY_DELAY_CYC = BUSY_DELAY_MS * (CLK_HZ / 1000);
  localparam int AUTO_PERIOD_S = 64;
  localparam logic [5:0] AUTO_LAST = 6'(AUTO_PERIOD_S - 1);
  localparam int RATE_1HZ_BIT = 15;
  localparam int RATE_1K_BIT = 5;
  localparam int RATE_4K_BIT = 3;
  localparam int RATE_8K_BIT = 2;

  typedef struct packed {
    logic osc_disable_on_battery;
    logic battery_output_enable;
    logic convert_temperature;
    logic rate_select_hi;
    logic rate_select_lo;
    logic interrupt_mode_select;
    logic alarm2_irq_enable;
    logic alarm1_irq_enable;
  } rtcc_ctl_t;

  typedef struct packed {
    logic oscillator_stopped_flag;
    logic [2:0] zero;
    logic crystal_clock_out_enable;
    logic compensation_busy;
    logic alarm2_flag;
    logic alarm1_flag;
  } rtcc_sts_t;

  typedef enum logic [1:0] {
    CV_IDLE, CV_USER_WAIT, CV_USER_BUSY, CV_AUTO
  } rtcc_cv_t;

  typedef struct packed {
    rtcc_ctl_t ctl;
    rtcc_sts_t sts;
    rtcc_cv_t cv;
    logic [15:0] dly;
    logic [5:0] per;
    logic convert_temperature_start;
    logic osc_run;
    logic pin_o;
    logic pin_oe;
    logic clk32_oe;
    logic [7:0] rdata;
  } rtcc_st_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic wave;
    logic clk32;
  } rtcc_div_t;
endpackage : rtcc_pkg

//--- src/rtcc_wave_div.sv
/*
  Square-wave divider fed by crystal edge pulses.
  Assumes tick_i pulses once per half period of the 32.768 kHz crystal.
*/
`timescale 1ns/1ns
module rtcc_wave_div (
  input wire logic sys_clk_i, // System clock
  input wire logic rst_b_i, // Sync reset, active low
  input wire logic tick_i, // Crystal half-period pulse
  input wire logic run_i, // Oscillator running
  input wire logic [1:0] rate_i, // Rate select
  output logic wave_o, // Selected square wave
  output logic clk32_o // 32.768 kHz wave
);
  rtcc_pkg::rtcc_div_t st_ff;
  rtcc_pkg::rtcc_div_t nxt_st;

  function automatic int rate_bit(input logic [1:0] r);
    case (r)
      2'h0: rate_bit = rtcc_pkg::RATE_1HZ_BIT;
      2'h1: rate_bit = rtcc_pkg::RATE_1K_BIT;
      2'h2: rate_bit = rtcc_pkg::RATE_4K_BIT;
      default: rate_bit = rtcc_pkg::RATE_8K_BIT;
    endcase
  endfunction : rate_bit

  always_comb begin
    nxt_st = st_ff;
    if (tick_i && run_i) begin
      nxt_st.cnt = st_ff.cnt + 16'h0001;
    end
    nxt_st.wave = nxt_st.cnt[rate_bit(rate_i)]; // RULE10
    nxt_st.clk32 = nxt_st.cnt[0];
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wave_o = st_ff.wave;
  assign clk32_o = st_ff.clk32;
endmodule : rtcc_wave_div

//--- src/rtcc_ctrl_status.sv
/*
  Control and status registers of a real-time clock: oscillator
  gating, conversion handshake, square-wave routing, alarm flags.
  Assumes a serial slave engine presents byte register accesses
  and that all inputs are synchronous to sys_clk_i.
*/
// Functional notes
// (RULE1) Disable bit stops oscillator only on battery
// (RULE2) Main supply keeps oscillator always running
// (RULE3) Control resets to 0x1c
// (RULE4) Shared pin floats on power fail unless enabled
// (RULE5) Convert write starts conversion only when idle
// (RULE6) User conversion leaves 64 s schedule alone
// (RULE7) Busy unchanged for 2 ms after user start
// (RULE8) Convert bit reads 1 until done
// (RULE9) Host checks busy, polls convert bit
// (RULE10) Rate field picks square-wave frequency
// (RULE11) Mode bit routes wave or alarm interrupt
// (RULE12) Alarm flags set regardless of mode bit
// (RULE13) Alarm 2 interrupts when enabled and mode 1
// (RULE14) Alarm 1 interrupts when enabled and mode 1
// (RULE15) Stop flag sets whenever oscillator halts
// (RULE16) Stop flag holds until written zero
// (RULE17) 32 kHz pin driven when enabled, resets 1; code drives it only while the oscillator runs
// (RULE18) Busy set on request, cleared at idle
// (RULE19) Alarm 2 flag clears on write zero only
// (RULE20) Alarm 1 flag clears on write zero only
// (RULE21) Alarm matches taken on the seconds update
// (RULE22) Status bits 6..4 read zero
`timescale 1ns/1ns
module rtcc_ctrl_status #(
  parameter int BUSY_DELAY_CYC = rtcc_pkg::BUSY_DELAY_CYC
) (
  input wire logic sys_clk_i, // 25 MHz clock
  input wire logic rst_b_i, // Sync reset, active low
  input wire logic [7:0] reg_addr_i, // Register address
  input wire logic reg_wr_i, // Write strobe
  input wire logic [7:0] reg_wdata_i, // Write data
  output logic [7:0] reg_rdata_o, // Read data
  input wire logic on_battery_i, // Running from battery
  input wire logic vcc_fail_i, // Main supply below trip
  input wire logic supplies_low_i, // Both supplies too low
  input wire logic osc_fault_i, // Crystal stopped by fault
  input wire logic xtal_tick_i, // Crystal half-period pulse
  input wire logic sec_tick_i, // Once-per-second update
  input wire logic alarm1_match_i, // Alarm 1 compare equal
  input wire logic alarm2_match_i, // Alarm 2 compare equal
  input wire logic convert_temperature_done_i, // Compensation now idle
  output logic convert_temperature_start_o, // Conversion request pulse
  output logic osc_run_o, // Oscillator enable
  output logic irq_or_wave_pin_o, // Shared pin value
  output logic irq_or_wave_pin_oe_o, // Shared pin drive
  output logic clk32_pin_o, // 32 kHz pin value
  output logic clk32_pin_oe_o // 32 kHz pin drive
);
  rtcc_pkg::rtcc_st_t st_ff;
  rtcc_pkg::rtcc_st_t nxt_st;
  rtcc_pkg::rtcc_st_t rst_st;
  logic wave;
  logic clk32;
  logic wr_ctl;
  logic wr_sts;
  logic in_prog;
  logic user_req;
  logic auto_hit;
  logic a1_set;
  logic a2_set;
  logic irq;

  function automatic logic hit(
    input logic [7:0] a,
    input logic [7:0] r
  );
    hit = (a == r);
  endfunction : hit

  rtcc_wave_div u_div (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .tick_i(xtal_tick_i),
    .run_i(st_ff.osc_run),
    .rate_i({st_ff.ctl.rate_select_hi, st_ff.ctl.rate_select_lo}),
    .wave_o(wave),
    .clk32_o(clk32)
  );

  always_comb begin
    rst_st = '0;
    rst_st.ctl = rtcc_pkg::CTL_RST; // RULE3
    rst_st.sts = rtcc_pkg::STS_RST; // RULE17
    rst_st.cv = rtcc_pkg::CV_IDLE;
    rst_st.osc_run = 1'b1;
    rst_st.pin_o = 1'b1;
  end

  assign wr_ctl = reg_wr_i && hit(reg_addr_i, rtcc_pkg::CTL_ADDR);
  assign wr_sts = reg_wr_i && hit(reg_addr_i, rtcc_pkg::STS_ADDR);
  assign in_prog = st_ff.sts.compensation_busy
                 | st_ff.ctl.convert_temperature;
  // A new request is honoured only when nothing runs
  assign user_req = wr_ctl && reg_wdata_i[rtcc_pkg::CONVERT_TEMPERATURE_BIT]
                 && !in_prog; // RULE5
  assign auto_hit = sec_tick_i
                 && (st_ff.per == rtcc_pkg::AUTO_LAST);
  assign a1_set = sec_tick_i && alarm1_match_i; // RULE21
  assign a2_set = sec_tick_i && alarm2_match_i; // RULE21

  always_comb begin
    nxt_st = st_ff;
    nxt_st.convert_temperature_start = 1'b0;

    // Free-running 64 s schedule, never restarted
    if (sec_tick_i) begin
      nxt_st.per = st_ff.per + 6'h01; // RULE6
    end

    if (wr_ctl) begin
      nxt_st.ctl = rtcc_pkg::rtcc_ctl_t'(reg_wdata_i);
      nxt_st.ctl.convert_temperature =
        st_ff.ctl.convert_temperature | user_req; // RULE8
    end

    case (st_ff.cv)
      rtcc_pkg::CV_IDLE: begin
        if (user_req) begin
          nxt_st.cv = rtcc_pkg::CV_USER_WAIT;
          nxt_st.dly = 16'(BUSY_DELAY_CYC - 1);
          nxt_st.convert_temperature_start = 1'b1; // RULE5
        end else if (auto_hit) begin
          nxt_st.cv = rtcc_pkg::CV_AUTO;
          nxt_st.convert_temperature_start = 1'b1;
          nxt_st.sts.compensation_busy = 1'b1; // RULE18
        end
      end
      rtcc_pkg::CV_USER_WAIT: begin
        if (convert_temperature_done_i) begin
          nxt_st.cv = rtcc_pkg::CV_IDLE;
          nxt_st.ctl.convert_temperature = 1'b0; // RULE8
          nxt_st.sts.compensation_busy = 1'b0;
        end else if (st_ff.dly == 16'h0000) begin
          nxt_st.cv = rtcc_pkg::CV_USER_BUSY;
          nxt_st.sts.compensation_busy = 1'b1; // RULE7
        end else begin
          nxt_st.dly = st_ff.dly - 16'h0001; // RULE7
        end
      end
      rtcc_pkg::CV_USER_BUSY: begin
        if (convert_temperature_done_i) begin
          nxt_st.cv = rtcc_pkg::CV_IDLE;
          nxt_st.ctl.convert_temperature = 1'b0; // RULE8
          nxt_st.sts.compensation_busy = 1'b0; // RULE18
        end
      end
      rtcc_pkg::CV_AUTO: begin
        if (convert_temperature_done_i) begin
          nxt_st.cv = rtcc_pkg::CV_IDLE;
          nxt_st.sts.compensation_busy = 1'b0; // RULE18
        end
      end
      default: begin
        nxt_st.cv = rtcc_pkg::CV_IDLE;
      end
    endcase

    // Oscillator gating from the newly written control value
    nxt_st.osc_run = !(nxt_st.ctl.osc_disable_on_battery
                      && on_battery_i) // RULE1 RULE2
                   && !supplies_low_i && !osc_fault_i;

    // Status writes: flags only clear, set wins over clear
    if (wr_sts) begin
      nxt_st.sts.crystal_clock_out_enable =
        reg_wdata_i[rtcc_pkg::EN32_BIT]; // RULE17
      nxt_st.sts.oscillator_stopped_flag =
        st_ff.sts.oscillator_stopped_flag
        & reg_wdata_i[rtcc_pkg::OSF_BIT]; // RULE16
      nxt_st.sts.alarm2_flag = st_ff.sts.alarm2_flag
        & reg_wdata_i[rtcc_pkg::A2F_BIT]; // RULE19
      nxt_st.sts.alarm1_flag = st_ff.sts.alarm1_flag
        & reg_wdata_i[rtcc_pkg::A1F_BIT]; // RULE20
    end
    if (!nxt_st.osc_run) begin
      nxt_st.sts.oscillator_stopped_flag = 1'b1; // RULE15
    end
    if (a2_set) begin
      nxt_st.sts.alarm2_flag = 1'b1; // RULE12 RULE19
    end
    if (a1_set) begin
      nxt_st.sts.alarm1_flag = 1'b1; // RULE12 RULE20
    end
    nxt_st.sts.zero = 3'h0; // RULE22

    // Shared pin routing
    irq = nxt_st.ctl.interrupt_mode_select
        & ((nxt_st.sts.alarm2_flag
            & nxt_st.ctl.alarm2_irq_enable) // RULE13
         | (nxt_st.sts.alarm1_flag
            & nxt_st.ctl.alarm1_irq_enable)); // RULE14
    nxt_st.pin_o = nxt_st.ctl.interrupt_mode_select
                 ? !irq : wave; // RULE11
    nxt_st.pin_oe = !(vcc_fail_i
                 && !nxt_st.ctl.battery_output_enable); // RULE4
    nxt_st.clk32_oe = nxt_st.sts.crystal_clock_out_enable
                    && nxt_st.osc_run; // RULE17

    // Registered read port
    if (hit(reg_addr_i, rtcc_pkg::CTL_ADDR)) begin
      nxt_st.rdata = nxt_st.ctl;
    end else if (hit(reg_addr_i, rtcc_pkg::STS_ADDR)) begin
      nxt_st.rdata = nxt_st.sts;
    end else begin
      nxt_st.rdata = 8'h00;
    end
  end


  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      st_ff <= rst_st;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata_o = st_ff.rdata;
  assign convert_temperature_start_o = st_ff.convert_temperature_start;
  assign osc_run_o = st_ff.osc_run;
  assign irq_or_wave_pin_o = st_ff.pin_o;
  assign irq_or_wave_pin_oe_o = st_ff.pin_oe;
  assign clk32_pin_o = clk32;
  assign clk32_pin_oe_o = st_ff.clk32_oe;

  // Checks
  default clocking dcb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  AST_OSC_BATT: assert property ( // RULE1
    st_ff.ctl.osc_disable_on_battery && on_battery_i && !wr_ctl
    |=> !osc_run_o)
    else $error("oscillator not stopped on battery");

  AST_OSC_MAIN: assert property ( // RULE2
    !on_battery_i && !supplies_low_i && !osc_fault_i |=> osc_run_o)
    else $error("oscillator stopped on main supply");

  AST_PIN_TRI: assert property ( // RULE4
    vcc_fail_i && !wr_ctl && !st_ff.ctl.battery_output_enable
    |=> !irq_or_wave_pin_oe_o)
    else $error("shared pin driven after power fail");

  AST_CONVERT_TEMPERATURE_BUSY_IGN: assert property ( // RULE5
    wr_ctl && reg_wdata_i[5] && st_ff.cv == rtcc_pkg::CV_AUTO
    |=> !st_ff.ctl.convert_temperature && !convert_temperature_start_o)
    else $error("conversion accepted while busy");

  AST_BUSY_WAIT: assert property ( // RULE7
    st_ff.cv == rtcc_pkg::CV_IDLE && user_req
    |=> !st_ff.sts.compensation_busy [*8])
    else $error("busy rose too early");

  AST_CONVERT_TEMPERATURE_DONE: assert property ( // RULE8
    st_ff.ctl.convert_temperature && convert_temperature_done_i
    |=> !st_ff.ctl.convert_temperature
        && !st_ff.sts.compensation_busy)
    else $error("convert bit not cleared at done");

  AST_CONVERT_TEMPERATURE_HOLD: assert property ( // RULE8
    st_ff.ctl.convert_temperature && !convert_temperature_done_i
    |=> st_ff.ctl.convert_temperature)
    else $error("convert bit dropped early");

  AST_IRQ2: assert property ( // RULE13
    st_ff.sts.alarm2_flag && st_ff.ctl.alarm2_irq_enable
    && st_ff.ctl.interrupt_mode_select |-> !irq_or_wave_pin_o)
    else $error("alarm 2 interrupt not asserted");

  AST_A1_SET: assert property ( // RULE20
    sec_tick_i && alarm1_match_i |=> st_ff.sts.alarm1_flag)
    else $error("alarm 1 flag not set");

  AST_A2_CLR: assert property ( // RULE19
    wr_sts && !reg_wdata_i[1] && !a2_set
    |=> !st_ff.sts.alarm2_flag)
    else $error("alarm 2 flag not cleared");

  AST_OSF_HOLD: assert property ( // RULE16
    st_ff.sts.oscillator_stopped_flag && !(wr_sts && !reg_wdata_i[7])
    |=> st_ff.sts.oscillator_stopped_flag)
    else $error("stop flag lost");

  AST_RSVD: assert property ( // RULE22
    reg_rdata_o[6:4] == 3'h0 || $past(reg_addr_i) != rtcc_pkg::STS_ADDR)
    else $error("reserved status bits not zero");
endmodule : rtcc_ctrl_status

//--- sim/rtcc_comp_model.sv
/*
  Behavioural compensation engine: answers each conversion request
  with an idle pulse after dly_i cycles. Assumes sync active-low reset.
*/
`timescale 1ns/1ns
module rtcc_comp_model (
  input wire logic sys_clk_i, // System clock
  input wire logic rst_b_i, // Sync reset, active low
  input wire logic [7:0] dly_i, // Request to idle delay
  input wire logic start_i, // Conversion request
  output logic done_o // Idle reached pulse
);
  logic [8:0] cnt_ff = 9'h000;
  logic done_ff = 1'b0;
  assign done_o = done_ff;
  always @(posedge sys_clk_i) begin
    done_ff <= 1'b0;
    if (!rst_b_i) begin
      cnt_ff <= 9'h000;
    end else if (start_i) begin
      cnt_ff <= {1'b0, dly_i};
    end else if (cnt_ff != 9'h000) begin
      cnt_ff <= cnt_ff - 9'h001;
      done_ff <= (cnt_ff == 9'h001);
    end
  end
endmodule : rtcc_comp_model

//--- sim/rtcc_ctrl_status_tb.sv
/*
  Self-checking bench for the control/status block.
  Assumes the compensation model answers conversion requests.
*/
`timescale 1ns/1ns
module rtcc_ctrl_status_tb;
  localparam logic [7:0] CTL = rtcc_pkg::CTL_ADDR;
  localparam logic [7:0] STS = rtcc_pkg::STS_ADDR;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] cdly = 8'h1e;
  logic wr = 1'b0, bat = 1'b0, vfail = 1'b0, xt = 1'b1, sec = 1'b0, m1 = 1'b0, m2 = 1'b0;
  logic [7:0] rdata;
  logic done, start, orun, pin, pin_oe, c32, c32_oe;
  logic rd_v = 1'b0;
  logic rd_d = 1'b0;
  int bad_count = 0, n_checks = 0, cyc = 0, n_start = 0, seed = 68;
  int hp[4] = '{32768, 32, 8, 4};
  logic [7:0] exp_q[$];
  always #20 sys_clk = ~sys_clk;
  rtcc_ctrl_status #(.BUSY_DELAY_CYC(10)) u_dut (.sys_clk_i(sys_clk), .rst_b_i(rst_b),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .on_battery_i(bat), .vcc_fail_i(vfail), .supplies_low_i(1'b0), .osc_fault_i(1'b0),
    .xtal_tick_i(xt), .sec_tick_i(sec), .alarm1_match_i(m1), .alarm2_match_i(m2),
    .convert_temperature_done_i(done), .convert_temperature_start_o(start), .osc_run_o(orun), .irq_or_wave_pin_o(pin),
    .irq_or_wave_pin_oe_o(pin_oe), .clk32_pin_o(c32), .clk32_pin_oe_o(c32_oe));
  rtcc_comp_model u_comp (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .dly_i(cdly),
    .start_i(start), .done_o(done));
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  // Read data lands one cycle after the address; compared a cycle later
  always @(posedge sys_clk) begin
    rd_d <= rd_v;
    cyc <= cyc + 1;
    if (start === 1'b1) begin
      n_start <= n_start + 1;
    end
    if (rd_d) begin
      chk("read data", {24'h0, exp_q.pop_front()}, {24'h0, rdata});
    end
    if (cyc == 90000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic tk(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge sys_clk);
    wr = 1'b0;
  endtask : wr_reg
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    addr = a;
    exp_q.push_back(e);
    rd_v = 1'b1;
    @(negedge sys_clk);
    rd_v = 1'b0;
  endtask : rd
  task automatic sec_evt(input logic a1, input logic a2);
    @(negedge sys_clk);
    m1 = a1;
    m2 = a2;
    sec = 1'b1;
    @(negedge sys_clk);
    sec = 1'b0;
    m1 = 1'b0;
    m2 = 1'b0;
  endtask : sec_evt
  initial begin
    logic p;
    int w;
    tk(10);
    rst_b = 1'b1;
    rd(CTL, 8'h1c);
    rd(STS, 8'h88);
    wr_reg(STS, 8'hf8);
    rd(STS, 8'h88);
    wr_reg(STS, 8'h78);
    rd(STS, 8'h08);
    wr_reg(8'h10, 8'($random(seed)));
    rd(CTL, 8'h1c);
    rd(8'h10, 8'h00);
    $display("test registers done");
    m1 = 1'b1;
    tk(3);
    m1 = 1'b0;
    rd(STS, 8'h08);
    sec_evt(1'b1, 1'b0);
    rd(STS, 8'h09);
    chk("shared pin", 1, pin);
    wr_reg(CTL, 8'h1d);
    tk(2);
    chk("shared pin", 0, pin);
    wr_reg(STS, 8'h09);
    rd(STS, 8'h09);
    wr_reg(STS, 8'h08);
    tk(2);
    chk("shared pin", 1, pin);
    wr_reg(CTL, 8'h1a);
    sec_evt(1'b0, 1'b1);
    rd(STS, 8'h0a);
    wr_reg(CTL, 8'h1e);
    tk(2);
    chk("shared pin", 0, pin);
    wr_reg(CTL, 8'h1c);
    tk(2);
    chk("shared pin", 1, pin);
    wr_reg(STS, 8'h0b);
    rd(STS, 8'h0a);
    wr_reg(STS, 8'h08);
    rd(STS, 8'h08);
    $display("test alarms done");
    wr_reg(CTL, 8'h9c);
    tk(2);
    chk("osc run", 1, orun);
    bat = 1'b1;
    tk(3);
    chk("osc run", 0, orun);
    chk("32k drive", 0, c32_oe);
    p = c32;
    tk(2);
    chk("32k wave", p, c32);
    rd(STS, 8'h88);
    bat = 1'b0;
    wr_reg(STS, 8'h08);
    rd(STS, 8'h08);
    vfail = 1'b1;
    wr_reg(CTL, 8'h1c);
    tk(2);
    chk("pin drive", 0, pin_oe);
    wr_reg(CTL, 8'h5c);
    tk(2);
    chk("pin drive", 1, pin_oe);
    vfail = 1'b0;
    wr_reg(CTL, 8'h1c);
    wr_reg(STS, 8'h00);
    tk(2);
    chk("32k drive", 0, c32_oe);
    wr_reg(STS, 8'h08);
    tk(2);
    chk("32k drive", 1, c32_oe);
    p = c32;
    tk(1);
    chk("32k wave", !p, c32);
    $display("test power done");
    for (int i = 0; i < 2; i++) begin
      cdly = (i == 0) ? 8'h1e : 8'h03;
      rd(STS, 8'h08);
      wr_reg(CTL, 8'h3c);
      rd(CTL, 8'h3c);
      rd(STS, 8'h08);
      tk(15);
      if (i == 0) wr_reg(CTL, 8'h3c);
      rd(CTL, (i == 0) ? 8'h3c : 8'h1c);
      rd(STS, (i == 0) ? 8'h0c : 8'h08);
      tk(30);
      rd(CTL, 8'h1c);
      rd(STS, 8'h08);
      chk("conversion starts", i + 1, n_start);
    end
    // Automatic slot: 64th second pulse since reset, user request refused while it runs
    cdly = 8'h1e;
    repeat (61) sec_evt(1'b0, 1'b0);
    rd(STS, 8'h08);
    sec_evt(1'b0, 1'b0);
    rd(STS, 8'h0c);
    wr_reg(CTL, 8'h3c);
    rd(CTL, 8'h1c);
    tk(40);
    rd(STS, 8'h08);
    chk("conversion starts", 3, n_start);
    $display("test conversion done");
    for (int i = 0; i < 4; i++) begin
      wr_reg(CTL, {3'b000, 2'(i), 3'b000});
      tk(3);
      p = pin;
      w = 0;
      while (pin === p && w < 70000) begin
        tk(1);
        w++;
      end
      p = pin;
      w = 0;
      while (pin === p && w < 70000) begin
        tk(1);
        w++;
      end
      chk("wave half period", hp[i], w);
    end
    $display("test wave done");
    tk(3);
    give_verdict();
  end
endmodule : rtcc_ctrl_status_tb
